// >>> isc_top.sv
// interrupt servicing controller: flags, priority and three service modes
//
// Added by the designer: the register addresses and the Avalon-MM register port.
`include "isc_map.svh"
module isc_top #(
  parameter int NSRC = `ISC_NSRC
) (
  input wire logic clk_in, // 40 MHz clock
  input wire logic resetn_in, // async reset, low
  input wire logic [7:0] avs_address_in, // byte address
  input wire logic avs_read_in, // read request
  input wire logic avs_write_in, // write request
  input wire logic [3:0] avs_byteenable_in, // byte lanes
  input wire logic [31:0] avs_writedata_in, // write data
  output logic [31:0] avs_readdata_out, // read data
  output logic avs_waitrequest_out, // stall
  input wire logic [NSRC-1:0] req_in, // peripheral request pulses
  input wire logic cpu_ready_in, // cpu at instruction boundary
  input wire logic cpu_ie_in, // cpu interrupt enable
  input wire logic reti_in, // return from service pulse
  input wire logic [19:0] program_counter_in, // current pc
  input wire logic [15:0] program_status_word_in, // current psw
  input wire logic vec_valid_in, // vector read data valid
  input wire logic [19:0] vec_data_in, // vector table data
  input wire logic [19:0] bank_vector_in, // vector held in bank
  input wire logic macro_done_in, // macro transfer finished pulse
  input wire logic macro_zero_in, // macro counter reached zero
  output logic ack_out, // acknowledge pulse
  output logic [4:0] ack_src_out, // acknowledged source
  output logic stack_push_out, // push pulse
  output logic [19:0] stack_data_out, // word pushed
  output logic vec_rd_out, // vector read request
  output logic [19:0] vec_addr_out, // vector table address
  output logic branch_out, // branch pulse
  output logic [19:0] branch_addr_out, // branch target
  output logic cpu_suspend_out, // hold cpu execution
  output logic macro_start_out, // start macro transfer pulse
  output logic bank_save_out, // store pc and psw in bank
  output logic [2:0] bank_sel_out, // selected register bank
  output logic [19:0] save_pc_out, // pc to bank
  output logic [15:0] save_psw_out, // psw to bank
  output logic [7:0] watchdog_mode_out, // watchdog mode value
  output logic irq_out // event interrupt
);
  localparam int NB = NSRC - 16;

  isc_pkg::svc_state_e state_r;
  logic [NSRC-1:0] pend_r, mask_r, macro_r, cse_r;
  logic [2*NSRC-1:0] lvl_r;
  logic [3:0] inserv_r;
  logic nest_r, wd_nmi_r, nmi_pend_r, nmi_act_r;
  logic [7:0] wd_mode_r;
  logic [2:0] bank_r;
  logic [4:0] src_r;
  logic [`ISC_NEVT-1:0] evt_r, clr_r, stat, imask;

  // bus decode
  logic acc, rd_acc, wr_acc, ctl_hit;
  logic [7:0] wdat;
  logic [4:0] ctl_idx;
  assign acc = (avs_read_in | avs_write_in) & ~avs_waitrequest_out;
  assign rd_acc = acc & avs_read_in;
  assign wr_acc = acc & avs_write_in;
  assign ctl_idx = avs_address_in[6:2];
  assign ctl_hit = (avs_address_in < 8'(4 * NSRC));
  assign wdat = avs_writedata_in[7:0];

  // lowest set level in service, 4 when idle
  function automatic logic [2:0] top_level(input logic [3:0] s);
    top_level = 3'h4;
    for (int i = 3; i >= 0; i--) begin
      if (s[i]) begin
        top_level = 3'(i);
      end
    end
  endfunction : top_level

  function automatic logic [7:0] ctl_byte(input int i, input logic [NSRC-1:0] p,
      input logic [NSRC-1:0] m, input logic [NSRC-1:0] ms,
      input logic [NSRC-1:0] c, input logic [2*NSRC-1:0] l);
    ctl_byte = {p[i], m[i], ms[i], c[i], 2'b00, l[2*i +: 2]};
  endfunction : ctl_byte

  // watchdog source goes to the nmi path when so selected
  logic [NSRC-1:0] req_m;
  always_comb begin
    req_m = req_in;
    req_m[0] = req_in[0] & ~wd_nmi_r;
  end

  // candidates: macro ignores ie and levels, the rest need both
  logic [NSRC-1:0] cand_mac, cand_vec;
  assign cand_mac = pend_r & ~mask_r & macro_r;
  assign cand_vec = pend_r & ~mask_r & ~macro_r & {NSRC{cpu_ie_in}};

  logic mac_found, vec_found;
  logic [4:0] mac_idx, vec_idx;
  logic [1:0] vec_lvl;
  prio_pick #(.N(NSRC)) u_pick_mac (
    .cand_in(cand_mac),
    .lvl_in(lvl_r),
    .found_out(mac_found),
    .idx_out(mac_idx),
    .lvl_out()
  );
  prio_pick #(.N(NSRC)) u_pick_vec (
    .cand_in(cand_vec),
    .lvl_in(lvl_r),
    .found_out(vec_found),
    .idx_out(vec_idx),
    .lvl_out(vec_lvl)
  );

  // accept only a level above the one in service; level 3 may nest
  logic [2:0] top;
  logic vec_ok;
  assign top = top_level(inserv_r);
  assign vec_ok = vec_found && (({1'b0, vec_lvl} < top) ||
      (vec_lvl == 2'h3 && top == 3'h3 && nest_r));

  logic start_nmi, start_mac, start_vec, macro_end;
  assign start_nmi = (state_r == isc_pkg::ST_IDLE) && cpu_ready_in &&
      nmi_pend_r && !nmi_act_r;
  assign start_mac = (state_r == isc_pkg::ST_IDLE) && cpu_ready_in &&
      !start_nmi && mac_found;
  assign start_vec = (state_r == isc_pkg::ST_IDLE) && cpu_ready_in &&
      !start_nmi && !mac_found && vec_ok;
  assign macro_end = (state_r == isc_pkg::ST_MACRO) && macro_done_in;

  // pending flags: request set beats acknowledge or software clear
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pend_r <= '0;
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        if (req_m[i]) begin
          pend_r[i] <= 1'b1;
        end else if ((start_mac && mac_idx == 5'(i)) ||
            (start_vec && vec_idx == 5'(i))) begin
          pend_r[i] <= 1'b0;
        end else if (wr_acc && ctl_hit && ctl_idx == 5'(i) &&
            avs_byteenable_in[0]) begin
          pend_r[i] <= wdat[`ISC_CTL_PEND];
        end
      end
    end
  end

  // mask flags: one store reached from control and mask registers
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mask_r <= '1;
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        if (wr_acc && ctl_hit && ctl_idx == 5'(i) && avs_byteenable_in[0]) begin
          mask_r[i] <= wdat[`ISC_CTL_MASK];
        end else if (wr_acc && avs_address_in == `ISC_MASK_A && i < 16 &&
            avs_byteenable_in[i / 8]) begin
          mask_r[i] <= avs_writedata_in[i];
        end else if (wr_acc && avs_address_in == `ISC_MASK_B && i >= 16 &&
            avs_byteenable_in == 4'b0001) begin
          mask_r[i] <= avs_writedata_in[i % 16];
        end
      end
    end
  end

  // macro select: cleared by hardware when the counter runs out
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      macro_r <= '0;
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        if (macro_end && macro_zero_in && src_r == 5'(i)) begin
          macro_r[i] <= 1'b0;
        end else if (wr_acc && ctl_hit && ctl_idx == 5'(i) &&
            avs_byteenable_in[0]) begin
          macro_r[i] <= wdat[`ISC_CTL_MACRO];
        end
      end
    end
  end

  // context enable and level fields, plain software storage
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cse_r <= '0;
      lvl_r <= {NSRC{`ISC_LVL_RESET}};
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        if (wr_acc && ctl_hit && ctl_idx == 5'(i) && avs_byteenable_in[0]) begin
          cse_r[i] <= wdat[`ISC_CTL_CSE];
          lvl_r[2*i +: 2] <= wdat[1:0];
        end
      end
    end
  end

  // other control registers
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      nest_r <= 1'b0;
      wd_nmi_r <= 1'b0;
      wd_mode_r <= 8'h00;
      bank_r <= 3'h0;
    end else if (wr_acc && avs_byteenable_in[0]) begin
      if (avs_address_in == `ISC_NEST) begin
        nest_r <= wdat[0];
      end
      if (avs_address_in == `ISC_WD_SEL) begin
        wd_nmi_r <= wdat[0];
      end
      if (avs_address_in == `ISC_WD_MODE) begin
        wd_mode_r <= wdat;
      end
      if (avs_address_in == `ISC_CTX_BANK) begin
        bank_r <= wdat[2:0];
      end
    end
  end

  // non-maskable watchdog: pending and active flags
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      nmi_pend_r <= 1'b0;
      nmi_act_r <= 1'b0;
    end else begin
      if (req_in[0] && wd_nmi_r) begin
        nmi_pend_r <= 1'b1;
      end else if (start_nmi) begin
        nmi_pend_r <= 1'b0;
      end
      // a second nmi waits until the first one returns
      if (start_nmi) begin
        nmi_act_r <= 1'b1;
      end else if (reti_in) begin
        nmi_act_r <= 1'b0;
      end
    end
  end

  // in-service levels; a return ends the nmi first, else the top level
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      inserv_r <= 4'h0;
    end else if (start_vec) begin
      inserv_r[vec_lvl] <= 1'b1;
    end else if (reti_in && !nmi_act_r && top != 3'h4) begin
      inserv_r[top[1:0]] <= 1'b0;
    end
  end

  // service sequencer and its cpu-facing strobes
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= isc_pkg::ST_IDLE;
      src_r <= 5'h0;
      ack_out <= 1'b0;
      ack_src_out <= 5'h0;
      stack_push_out <= 1'b0;
      stack_data_out <= 20'h0_0000;
      vec_rd_out <= 1'b0;
      vec_addr_out <= 20'h0_0000;
      branch_out <= 1'b0;
      branch_addr_out <= 20'h0_0000;
      cpu_suspend_out <= 1'b0;
      macro_start_out <= 1'b0;
      bank_save_out <= 1'b0;
      bank_sel_out <= 3'h0;
      save_pc_out <= 20'h0_0000;
      save_psw_out <= 16'h0000;
    end else begin
      ack_out <= 1'b0;
      stack_push_out <= 1'b0;
      branch_out <= 1'b0;
      macro_start_out <= 1'b0;
      bank_save_out <= 1'b0;
      unique case (state_r)
        isc_pkg::ST_IDLE: begin
          if (start_nmi) begin
            ack_out <= 1'b1;
            ack_src_out <= 5'h0;
            vec_addr_out <= `ISC_NMI_VEC;
            state_r <= isc_pkg::ST_PUSH_PSW;
          end else if (start_mac) begin
            // cpu state untouched: only a suspend, no push
            ack_out <= 1'b1;
            ack_src_out <= mac_idx;
            src_r <= mac_idx;
            cpu_suspend_out <= 1'b1;
            macro_start_out <= 1'b1;
            state_r <= isc_pkg::ST_MACRO;
          end else if (start_vec) begin
            ack_out <= 1'b1;
            ack_src_out <= vec_idx;
            src_r <= vec_idx;
            vec_addr_out <= `ISC_VEC_BASE + {14'h0, vec_idx, 1'b0};
            state_r <= cse_r[vec_idx] ? isc_pkg::ST_CTX_SAVE :
                isc_pkg::ST_PUSH_PSW;
          end
        end
        isc_pkg::ST_PUSH_PSW: begin
          stack_push_out <= 1'b1;
          stack_data_out <= {4'h0, program_status_word_in};
          state_r <= isc_pkg::ST_PUSH_PC;
        end
        isc_pkg::ST_PUSH_PC: begin
          stack_push_out <= 1'b1;
          stack_data_out <= program_counter_in;
          vec_rd_out <= 1'b1;
          state_r <= isc_pkg::ST_VEC_RD;
        end
        isc_pkg::ST_VEC_RD: begin
          if (vec_valid_in) begin
            vec_rd_out <= 1'b0;
            branch_out <= 1'b1;
            branch_addr_out <= vec_data_in;
            state_r <= isc_pkg::ST_IDLE;
          end
        end
        isc_pkg::ST_MACRO: begin
          if (macro_done_in) begin
            cpu_suspend_out <= 1'b0;
            state_r <= isc_pkg::ST_IDLE;
          end
        end
        isc_pkg::ST_CTX_SAVE: begin
          // bank chosen first so its stored vector is ready next cycle
          bank_sel_out <= bank_r;
          bank_save_out <= 1'b1;
          save_pc_out <= program_counter_in;
          save_psw_out <= program_status_word_in;
          state_r <= isc_pkg::ST_CTX_BRANCH;
        end
        isc_pkg::ST_CTX_BRANCH: begin
          branch_out <= 1'b1;
          branch_addr_out <= bank_vector_in;
          state_r <= isc_pkg::ST_IDLE;
        end
        default: begin
          state_r <= isc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // events for software
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      evt_r <= '0;
    end else begin
      evt_r[`ISC_EV_VEC] <= start_vec && !cse_r[vec_idx];
      evt_r[`ISC_EV_MACRO] <= start_mac;
      evt_r[`ISC_EV_CTX] <= start_vec && cse_r[vec_idx];
      evt_r[`ISC_EV_MEND] <= macro_end && macro_zero_in;
      evt_r[`ISC_EV_NMI] <= start_nmi;
    end
  end

  irq_status #(.W(`ISC_NEVT)) u_irq (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .event_in(evt_r),
    .clr_in(clr_r),
    .mask_we_in(wr_acc && avs_address_in == `ISC_IRQ_MASK &&
        avs_byteenable_in[0]),
    .mask_in(avs_writedata_in[`ISC_NEVT-1:0]),
    .status_out(stat),
    .mask_out(imask),
    .irq_out(irq_out)
  );

  // read mux; status clears only what the captured word showed
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    if (ctl_hit) begin
      rdata[7:0] = ctl_byte(int'(ctl_idx), pend_r, mask_r, macro_r, cse_r,
          lvl_r);
    end else begin
      unique case (avs_address_in)
        `ISC_MASK_A: rdata[15:0] = mask_r[15:0];
        `ISC_MASK_B: rdata[NB-1:0] = mask_r[NSRC-1:16];
        `ISC_INSERV: rdata[3:0] = inserv_r;
        `ISC_NEST: rdata[0] = nest_r;
        `ISC_WD_SEL: rdata[0] = wd_nmi_r;
        `ISC_WD_MODE: rdata[7:0] = wd_mode_r;
        `ISC_IRQ_STAT: rdata[`ISC_NEVT-1:0] = stat;
        `ISC_IRQ_MASK: rdata[`ISC_NEVT-1:0] = imask;
        `ISC_CTX_BANK: rdata[2:0] = bank_r;
        default: rdata = 32'h0000_0000;
      endcase
    end
  end

  // one wait cycle per access; data and answer land together
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
      clr_r <= '0;
    end else begin
      clr_r <= '0;
      if (acc) begin
        avs_waitrequest_out <= 1'b1;
        if (rd_acc && avs_address_in == `ISC_IRQ_STAT) begin
          clr_r <= avs_readdata_out[`ISC_NEVT-1:0];
        end
      end else if (avs_read_in || avs_write_in) begin
        avs_waitrequest_out <= 1'b0;
        avs_readdata_out <= avs_read_in ? rdata : 32'h0000_0000;
      end
    end
  end

  // watchdog mode straight from its register
  assign watchdog_mode_out = wd_mode_r;
endmodule : isc_top

// >>> isc_map.svh
// register map, field positions, reset values and fixed addresses
`ifndef ISC_MAP_SVH
`define ISC_MAP_SVH
`define ISC_NSRC 19
`define ISC_CTL_BASE 8'h00
`define ISC_MASK_A 8'h50
`define ISC_MASK_B 8'h54
`define ISC_INSERV 8'h58
`define ISC_NEST 8'h5C
`define ISC_WD_SEL 8'h60
`define ISC_WD_MODE 8'h64
`define ISC_IRQ_STAT 8'h68
`define ISC_IRQ_MASK 8'h6C
`define ISC_CTX_BANK 8'h70
`define ISC_CTL_PEND 7
`define ISC_CTL_MASK 6
`define ISC_CTL_MACRO 5
`define ISC_CTL_CSE 4
`define ISC_CTL_RESET 8'h43
`define ISC_LVL_RESET 2'h3
`define ISC_VEC_BASE 20'h0_0006
`define ISC_NMI_VEC 20'h0_0004
`define ISC_NEVT 5
`define ISC_EV_VEC 0
`define ISC_EV_MACRO 1
`define ISC_EV_CTX 2
`define ISC_EV_MEND 3
`define ISC_EV_NMI 4
`endif

// >>> isc_pkg.sv
// types shared by the interrupt servicing files
package isc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_PUSH_PSW, ST_PUSH_PC, ST_VEC_RD, ST_BRANCH,
    ST_MACRO, ST_CTX_SAVE, ST_CTX_BRANCH
  } svc_state_e;
  typedef logic [1:0] level_t;
  typedef logic [19:0] addr_t;
endpackage : isc_pkg

// >>> prio_pick.sv
// picks the best pending source: lowest level, then lowest source number
module prio_pick #(
  parameter int N = 19
) (
  input wire logic [N-1:0] cand_in, // eligible sources
  input wire logic [2*N-1:0] lvl_in, // two level bits per source
  output logic found_out, // any candidate
  output logic [4:0] idx_out, // winning source number
  output logic [1:0] lvl_out // winning level
);
  // scan from the top so that a tie leaves the lower number in place
  always_comb begin
    found_out = 1'b0;
    idx_out = 5'h0;
    lvl_out = 2'h3;
    for (int i = N - 1; i >= 0; i--) begin
      if (cand_in[i] && (!found_out || lvl_in[2*i +: 2] <= lvl_out)) begin
        found_out = 1'b1;
        idx_out = 5'(i);
        lvl_out = lvl_in[2*i +: 2];
      end
    end
  end
endmodule : prio_pick

// >>> irq_status.sv
// sticky event status, mask and one level interrupt line
module irq_status #(
  parameter int W = 5
) (
  input wire logic clk_in, // clock
  input wire logic resetn_in, // async reset, low
  input wire logic [W-1:0] event_in, // one-cycle event pulses
  input wire logic [W-1:0] clr_in, // bits read, now cleared
  input wire logic mask_we_in, // mask write strobe
  input wire logic [W-1:0] mask_in, // new mask
  output logic [W-1:0] status_out, // sticky status
  output logic [W-1:0] mask_out, // mask, 1 enables
  output logic irq_out // level interrupt
);
  // set wins over the read clear so no event is lost
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status_out <= '0;
    end else begin
      status_out <= (status_out & ~clr_in) | event_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mask_out <= '0;
    end else if (mask_we_in) begin
      mask_out <= mask_in;
    end
  end

  // registered, so the line lags the status by one cycle
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status_out & mask_out);
    end
  end
endmodule : irq_status

// >>> isc_cpu_model.sv
// cpu-side partner: vector table reads and macro transfer engine
module isc_cpu_model (
  input wire logic clk_in, // clock
  input wire logic resetn_in, // async reset, low
  input wire logic slow_in, // answer late
  input wire logic vec_rd_in, // vector read request
  input wire logic [19:0] vec_addr_in, // vector address
  input wire logic macro_start_in, // transfer start pulse
  output logic vec_valid_out, // vector answer pulse
  output logic [19:0] vec_data_out, // vector word
  output logic macro_done_out, // transfer end pulse
  output logic macro_zero_out // counter at zero
);
  logic [2:0] vwait_r;
  logic [2:0] mwait_r;
  // idle data is inverted so a stale word never passes for an answer
  assign vec_data_out = vec_valid_out ? {vec_addr_in[15:0], 4'h5}
    : ~{vec_addr_in[15:0], 4'h5};
  assign macro_zero_out = macro_done_out;
  // one answer per read, after one or five cycles
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      vwait_r <= 3'h0;
      vec_valid_out <= 1'b0;
    end else begin
      vwait_r <= (vec_rd_in && !vec_valid_out) ? vwait_r + 3'h1 : 3'h0;
      vec_valid_out <= vec_rd_in && !vec_valid_out &&
        vwait_r == (slow_in ? 3'h4 : 3'h0);
    end
  end
  // every transfer empties the counter, so the select flag must drop
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mwait_r <= 3'h0;
      macro_done_out <= 1'b0;
    end else begin
      if (macro_start_in) mwait_r <= 3'h5;
      else if (mwait_r != 3'h0) mwait_r <= mwait_r - 3'h1;
      macro_done_out <= mwait_r == 3'h1;
    end
  end
endmodule : isc_cpu_model

// >>> isc_top_chk.sv
// concurrent checks on the service outputs of the controller
`include "isc_map.svh"
module isc_top_chk (
  input wire logic clk_in, // clock
  input wire logic resetn_in, // async reset, low
  input wire logic ack_out, // acknowledge
  input wire logic [4:0] ack_src_out, // source
  input wire logic stack_push_out, // push
  input wire logic vec_rd_out, // vector read
  input wire logic [19:0] vec_addr_out, // vector address
  input wire logic vec_valid_in, // vector answer
  input wire logic [19:0] vec_data_in, // vector word
  input wire logic branch_out, // branch
  input wire logic [19:0] branch_addr_out, // target
  input wire logic cpu_suspend_out, // cpu held
  input wire logic macro_start_out, // transfer start
  input wire logic macro_done_in, // transfer end
  input wire logic bank_save_out, // bank save
  input wire logic [19:0] bank_vector_in // bank vector
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // vectored entry: status word, then counter, right after acknowledge
  chk_push_order: assert property (
    $rose(stack_push_out) |-> $past(ack_out) ##1 stack_push_out
    ##1 !stack_push_out) else $error("push pair broken");
  chk_vec_entry: assert property (
    $rose(stack_push_out) |-> vec_addr_out == `ISC_NMI_VEC ||
    vec_addr_out == `ISC_VEC_BASE + {14'h0, ack_src_out, 1'b0})
    else $error("wrong vector entry");
  chk_vec_branch: assert property (
    vec_rd_out && vec_valid_in |=> branch_out && !vec_rd_out &&
    branch_addr_out == $past(vec_data_in)) else $error("bad branch");
  chk_macro_hold: assert property (
    macro_start_out |-> cpu_suspend_out && ack_out)
    else $error("macro start without hold");
  chk_macro_free: assert property (
    cpu_suspend_out && macro_done_in |=> !cpu_suspend_out)
    else $error("cpu held after transfer");
  chk_macro_nosave: assert property (
    cpu_suspend_out |-> !stack_push_out && !bank_save_out && !branch_out)
    else $error("state touched by macro");
  chk_ctx_branch: assert property (
    bank_save_out |=> branch_out && branch_addr_out == $past(bank_vector_in))
    else $error("bad bank branch");
  chk_ctx_nostack: assert property (
    bank_save_out |-> $past(ack_out) && !stack_push_out ##1 !stack_push_out)
    else $error("bank save used stack");
  chk_ack_single: assert property (
    ack_out |=> !ack_out [*2]) else $error("acknowledge too soon");
  cov_vec: cover property (vec_rd_out && vec_valid_in);
  cov_macro: cover property (cpu_suspend_out && macro_done_in);
  cov_ctx: cover property (bank_save_out);
endmodule : isc_top_chk
bind isc_top isc_top_chk i_isc_top_chk (.clk_in, .resetn_in, .ack_out,
  .ack_src_out, .stack_push_out, .vec_rd_out, .vec_addr_out, .vec_valid_in,
  .vec_data_in, .branch_out, .branch_addr_out, .cpu_suspend_out,
  .macro_start_out, .macro_done_in, .bank_save_out, .bank_vector_in);

// >>> tb_isc_top.sv
// self-checking bench for the interrupt servicing controller
module tb_isc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, resetn_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic cpu_ready_in, cpu_ie_in, reti_in, slow, ack_out, stack_push_out;
  logic vec_valid_in, macro_done_in, macro_zero_in, vec_rd_out, branch_out;
  logic cpu_suspend_out, macro_start_out, bank_save_out, irq_out;
  logic [7:0] avs_address_in, watchdog_mode_out;
  logic [3:0] avs_byteenable_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, seed;
  logic [18:0] req_in;
  logic [19:0] program_counter_in, vec_data_in, bank_vector_in, vec_addr_out;
  logic [19:0] branch_addr_out, save_pc_out, stack_data_out;
  logic [15:0] program_status_word_in, save_psw_out;
  logic [4:0] ack_src_out;
  logic [2:0] bank_sel_out;
  logic [31:0] rdq[$], ackq[$], brq[$];
  int mismatches, checks, nbr, ph;
  isc_top i_isc_top (.clk_in, .resetn_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_byteenable_in, .avs_writedata_in, .avs_readdata_out,
    .avs_waitrequest_out, .req_in, .cpu_ready_in, .cpu_ie_in, .reti_in,
    .program_counter_in, .program_status_word_in, .vec_valid_in,
    .vec_data_in, .bank_vector_in, .macro_done_in, .macro_zero_in, .ack_out,
    .ack_src_out, .stack_push_out, .stack_data_out, .vec_rd_out,
    .vec_addr_out, .branch_out, .branch_addr_out, .cpu_suspend_out,
    .macro_start_out, .bank_save_out, .bank_sel_out, .save_pc_out,
    .save_psw_out, .watchdog_mode_out, .irq_out);
  isc_cpu_model i_isc_cpu_model (.clk_in, .resetn_in, .slow_in(slow),
    .vec_rd_in(vec_rd_out), .vec_addr_in(vec_addr_out),
    .macro_start_in(macro_start_out), .vec_valid_out(vec_valid_in),
    .vec_data_out(vec_data_in), .macro_done_out(macro_done_in),
    .macro_zero_out(macro_zero_in));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // partner vector word for source n, -1 for nmi
  function automatic logic [31:0] vt(input int n);
    return {12'h0, 16'(6 + 2 * n), 4'h5};
  endfunction : vt
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic test_done();
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  // avalon access held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    do @(posedge clk_in); while (avs_waitrequest_out);
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rdq.push_back(exp);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
  endtask : rd
  // request or return pulse, new random cpu state
  task automatic pulse(input logic [18:0] m, input logic r);
    seed = lfsr(seed);
    @(posedge clk_in);
    req_in <= m;
    reti_in <= r;
    program_counter_in <= seed[19:0];
    program_status_word_in <= seed[31:16];
    bank_vector_in <= seed[23:4];
    slow <= seed[0];
    @(posedge clk_in);
    req_in <= 19'h0_0000;
    reti_in <= 1'b0;
  endtask : pulse
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = !clk_in;
  end
  // reads, acks and branches are checked against the oldest note; saves and pushes against live cpu state
  always @(negedge clk_in) begin
    if (avs_read_in && !avs_waitrequest_out)
      cmp(avs_readdata_out, rdq.pop_front());
    if (ack_out) cmp(32'(ack_src_out), ackq.pop_front());
    if (branch_out) cmp(32'(branch_addr_out), brq.pop_front());
    if (bank_save_out) cmp(32'({bank_sel_out, save_pc_out}),
      32'({3'h5, program_counter_in}));
    if (bank_save_out) cmp(32'(save_psw_out),
      32'(program_status_word_in));
    if (stack_push_out) cmp(32'(stack_data_out), ph ?
      32'(program_counter_in) : 32'(program_status_word_in));
    ph ^= stack_push_out;
    if (branch_out) nbr++;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    test_done();
  end
  initial begin
    {resetn_in, avs_read_in, avs_write_in, reti_in, slow} = 5'h00;
    {cpu_ready_in, cpu_ie_in, req_in, avs_address_in} = 29'h0;
    {avs_byteenable_in, avs_writedata_in, seed} = {36'h0, 32'h0000_fdf0};
    {program_counter_in, program_status_word_in, bank_vector_in} = 56'h0;
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    cpu_ready_in <= 1'b1;
    cpu_ie_in <= 1'b1;
    rd(8'h00, 32'h0000_0043);
    rd(8'h48, 32'h0000_0043);
    rd(8'h50, 32'h0000_ffff);
    rd(8'h54, 32'h0000_0007);
    bus(1'b1, 8'h0c, 32'h0000_0003, 4'h1);
    rd(8'h50, 32'h0000_fff7);
    bus(1'b1, 8'h50, 32'h0000_0000, 4'h2);
    rd(8'h50, 32'h0000_00f7);
    bus(1'b1, 8'h54, 32'h0000_0000, 4'h3);
    rd(8'h54, 32'h0000_0007);
    rd(8'h20, 32'h0000_0003);
    // three at once: level 1 first, then equal level 3 in default order
    bus(1'b1, 8'h14, 32'h0000_0001, 4'h1);
    bus(1'b1, 8'h5c, 32'h0000_0001, 4'h1);
    bus(1'b1, 8'h6c, 32'h0000_0008, 4'h1);
    ackq = '{32'd5, 32'd3, 32'd8};
    brq = '{vt(5), vt(3), vt(8)};
    pulse(19'h0_0128, 1'b0);
    wait (nbr == 1);
    rd(8'h14, 32'h0000_0001);
    rd(8'h58, 32'h0000_0002);
    pulse(19'h0_0000, 1'b1);
    wait (nbr == 3);
    rd(8'h58, 32'h0000_0008);
    pulse(19'h0_0000, 1'b1);
    rd(8'h58, 32'h0000_0000);
    // register bank switch for source 12
    bus(1'b1, 8'h70, 32'h0000_0005, 4'h1);
    bus(1'b1, 8'h30, 32'h0000_0010, 4'h1);
    ackq.push_back(32'd12);
    pulse(19'h0_1000, 1'b0);
    brq.push_back(32'(bank_vector_in));
    wait (nbr == 4);
    pulse(19'h0_0000, 1'b1);
    rd(8'h68, 32'h0000_0005);
    // macro transfer with interrupts disabled, end event raises irq
    cpu_ie_in <= 1'b0;
    bus(1'b1, 8'h3c, 32'h0000_0020, 4'h1);
    ackq.push_back(32'd15);
    pulse(19'h0_8000, 1'b0);
    wait (irq_out === 1'b1);
    rd(8'h3c, 32'h0000_0000);
    rd(8'h68, 32'h0000_000a);
    repeat (3) @(negedge clk_in);
    cmp(32'(irq_out), 32'h0000_0000);
    // watchdog routed as non-maskable, taken while masked and disabled
    bus(1'b1, 8'h64, 32'h0000_00a5, 4'h1);
    bus(1'b1, 8'h60, 32'h0000_0001, 4'h1);
    cmp(32'(watchdog_mode_out), 32'h0000_00a5);
    ackq.push_back(32'd0);
    brq.push_back(vt(-1));
    pulse(19'h0_0001, 1'b0);
    wait (nbr == 5);
    pulse(19'h0_0000, 1'b1);
    repeat (4) @(posedge clk_in);
    test_done();
  end
endmodule : tb_isc_top
